// ---- core/uart_regs_cfg.svh ----
`ifndef UART_REGS_CFG_SVH
`define UART_REGS_CFG_SVH
// ==========================================
// Register byte offsets
`define OFF_CLK 8'h00
`define OFF_MOD 8'h04
`define OFF_BR 8'h08
`define OFF_CTL 8'h0c
`define OFF_TXD 8'h10
`define OFF_RXD 8'h14
`define OFF_INTF 8'h18
`define OFF_INTE 8'h1c
// ==========================================
// Field positions and write masks
`define CLK_DEBUG_CLOCK_RUN 8
`define CLK_DIV 5:4
`define CLK_SRC 1:0
`define CLK_WMASK 16'h0133
`define SRC_INTERNAL 2'h0
`define SRC_HIGH_SPEED 2'h2
`define MOD_SAMPLING_DIVIDER_SEL 10
`define MOD_RECEIVE_INVERT 9
`define MOD_TRANSMIT_INVERT 8
`define MOD_INPUT_PULLUP_ENABLE 6
`define MOD_OUTPUT_DRIVE_MODE 5
`define MOD_INFRARED_MODE 4
`define MOD_DATA_LENGTH_SEL 3
`define MOD_PARITY_ENABLE 2
`define MOD_PARITY_TYPE 1
`define MOD_STOP_LENGTH_SEL 0
`define MOD_WMASK 16'h077f
`define BR_WMASK 16'h0fff
`define BR_FINE 11:8
`define BR_DIV 7:0
`define CTL_SRST 1
`define CTL_MODULE_ENABLE 0
`define FLG_TEND 6
`define FLG_FE 5
`define FLG_PE 4
`define FLG_OVR 3
// ==========================================
// Reset values and sample counts
`define TBE_RST 1'b1
`define SMP_LAST_16 4'hf
`define SMP_LAST_4 4'h3
`define IR_LOW_SMP 4'h3
`define IR_STRETCH 4'hf
`endif

// ---- core/uart_regs_pkg.sv ----
package uart_regs_pkg;
  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage

// ---- core/uart_baud_tick.sv ----
`timescale 1ns/10ps
module uart_baud_tick (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_op_tick,
  input wire logic i_restart,
  input wire logic [7:0] i_divisor,
  input wire logic [3:0] i_fine,
  input wire logic [3:0] i_last_phase,
  output logic o_samp_tick
);
  typedef struct packed {
    logic [8:0] cnt;
    logic [3:0] phase;
    logic tick;
  } bst_t;

  bst_t s;
  bst_t n;
  logic [8:0] target;

  // ==========================================
  // Sample period: divisor+1 op clocks, one more on the first fine phases of a bit
  always_comb begin
    n = s;
    n.tick = 1'b0;
    target = {1'b0, i_divisor} + ((s.phase < i_fine) ? 9'h001 : 9'h000);
    if (i_restart) begin
      n.cnt = 9'h000;
      n.phase = 4'h0;
    end else if (i_op_tick) begin
      if (s.cnt >= target) begin
        n.cnt = 9'h000;
        n.tick = 1'b1;
        n.phase = (s.phase >= i_last_phase) ? 4'h0 : s.phase + 4'h1;
      end else begin
        n.cnt = s.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_samp_tick = s.tick;

  // ==========================================
  // Checks
  a_tick_cause: assert property (@(posedge i_clk) disable iff (i_rst)
    o_samp_tick |-> $past(i_op_tick) && !$past(i_restart))
    else $error("sample tick without op clock");
  a_tick_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
    o_samp_tick && i_divisor != 8'h00 && $stable(i_divisor) |=> !o_samp_tick)
    else $error("sample ticks too close");
  c_stretch: cover property (@(posedge i_clk) disable iff (i_rst)
    i_op_tick && s.cnt == target && target != {1'b0, i_divisor});
endmodule

// ---- core/uart_regs_top.sv ----
`timescale 1ns/10ps
`include "uart_regs_cfg.svh"
module uart_regs_top #(
  parameter logic [3:0] SRC_PRESENT = 4'hf
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  input wire logic [3:0] I_SRC_TICK,
  input wire logic I_DEBUG_MODE,
  input wire logic I_SIN,
  output logic O_SOUT,
  output logic O_SOUT_OE,
  output logic O_SIN_PULLUP,
  output logic O_IRQ
);
  typedef struct packed {
    logic [15:0] clk_r;
    logic [15:0] mod_r;
    logic [15:0] br_r;
    logic module_enable;
    logic srst;
    logic [6:0] inte;
    logic [7:0] txbuf;
    logic tbe;
    logic tend;
    logic fe;
    logic pe;
    logic ovr;
    logic [1:0] cnt;
    logic [7:0] fifo0;
    logic [7:0] fifo1;
    logic [1:0] fe_q;
    logic [1:0] pe_q;
    logic [2:0] div_cnt;
    logic op_tick;
    uart_regs_pkg::tx_state_t txs;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic [3:0] tx_smp;
    logic tx_par;
    logic tx_line;
    uart_regs_pkg::rx_state_t rxs;
    logic [7:0] rx_sh;
    logic [2:0] rx_bit;
    logic [3:0] rx_smp;
    logic rx_par;
    logic [3:0] ir_cnt;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic pop_ok;
    logic irq;
    logic sout;
    logic sout_oe;
  } st_t;

  st_t s;
  st_t n;
  logic tx_tk, rx_tk, wr, rd, pop, push, tx_end, hit, run, rin, rx_line, line_out;
  logic fe_in, pe_in, fe_set, pe_set, ovr_set, transmit_busy, receive_busy;
  logic [6:0] clr;
  logic [6:0] flags;
  logic [15:0] rv;
  logic [7:0] rx_byte;
  logic [3:0] last;
  logic [2:0] len_last;
  logic [1:0] dsel;

  function automatic logic [3:0] last_smp(input logic quarter);
    return quarter ? `SMP_LAST_4 : `SMP_LAST_16;
  endfunction

  function automatic logic [2:0] div_last(input logic [1:0] code);
    case (code)
      2'h0: return 3'h0;
      2'h1: return 3'h1;
      2'h2: return 3'h3;
      default: return 3'h7;
    endcase
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic len8, input logic odd);
    return (^(len8 ? d : {1'b0, d[6:0]})) ^ odd;
  endfunction

  // ==========================================
  // Baud generators, one per direction, each realigned while its side idles
  uart_baud_tick u_tx_baud (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_op_tick(s.op_tick),
    .i_restart(s.txs == uart_regs_pkg::TX_IDLE),
    .i_divisor(s.br_r[`BR_DIV]),
    .i_fine(s.br_r[`BR_FINE]),
    .i_last_phase(last),
    .o_samp_tick(tx_tk)
  );
  uart_baud_tick u_rx_baud (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_op_tick(s.op_tick),
    .i_restart(s.rxs == uart_regs_pkg::RX_IDLE),
    .i_divisor(s.br_r[`BR_DIV]),
    .i_fine(s.br_r[`BR_FINE]),
    .i_last_phase(last),
    .o_samp_tick(rx_tk)
  );

  assign transmit_busy = s.txs != uart_regs_pkg::TX_IDLE;
  assign receive_busy = s.rxs != uart_regs_pkg::RX_IDLE;
  assign flags = {s.tend, s.fe, s.pe, s.ovr, s.cnt == 2'h2, s.cnt != 2'h0, s.tbe};
  assign last = last_smp(s.mod_r[`MOD_SAMPLING_DIVIDER_SEL]);
  assign len_last = s.mod_r[`MOD_DATA_LENGTH_SEL] ? 3'h7 : 3'h6;

  always_comb begin
    n = s;
    n.op_tick = 1'b0;
    fe_set = 1'b0;
    pe_set = 1'b0;
    ovr_set = 1'b0;
    push = 1'b0;
    fe_in = 1'b0;
    pe_in = 1'b0;
    tx_end = 1'b0;
    // ==========================================
    // APB: read data is latched in setup, so access always completes with no wait
    hit = 1'b1;
    case (I_PADDR)
      `OFF_CLK: rv = s.clk_r;
      `OFF_MOD: rv = s.mod_r;
      `OFF_BR: rv = s.br_r;
      `OFF_CTL: rv = {14'h0000, s.srst, s.module_enable};
      `OFF_TXD: rv = {8'h00, s.txbuf};
      `OFF_RXD: rv = {8'h00, s.fifo0};
      `OFF_INTF: rv = {6'h00, receive_busy, transmit_busy, 1'b0, flags};
      `OFF_INTE: rv = {9'h000, s.inte};
      default: begin
        rv = 16'h0000;
        hit = 1'b0;
      end
    endcase
    n.pready = I_PSEL & ~I_PENABLE;
    if (I_PSEL & ~I_PENABLE) begin
      n.prdata = {16'h0000, rv};
      n.pslverr = ~hit;
      // Pop only what was actually returned; a byte arriving after setup stays put
      n.pop_ok = (I_PADDR == `OFF_RXD) & ~I_PWRITE & (s.cnt != 2'h0);
    end
    wr = I_PSEL & I_PENABLE & s.pready & I_PWRITE;
    rd = I_PSEL & I_PENABLE & s.pready & ~I_PWRITE;
    pop = rd & (I_PADDR == `OFF_RXD) & s.pop_ok;
    clr = (wr && I_PADDR == `OFF_INTF) ? I_PWDATA[6:0] : 7'h00;
    if (wr) begin
      case (I_PADDR)
        `OFF_CLK: begin
          n.clk_r = I_PWDATA[15:0] & `CLK_WMASK;
          if (!SRC_PRESENT[I_PWDATA[1:0]]) begin
            n.clk_r[`CLK_SRC] = s.clk_r[`CLK_SRC];
          end
        end
        `OFF_MOD: n.mod_r = I_PWDATA[15:0] & `MOD_WMASK;
        `OFF_BR: n.br_r = I_PWDATA[15:0] & `BR_WMASK;
        `OFF_CTL: begin
          n.module_enable = I_PWDATA[`CTL_MODULE_ENABLE];
          if (I_PWDATA[`CTL_SRST]) begin
            n.srst = 1'b1;
          end
        end
        `OFF_TXD: begin
          n.txbuf = I_PWDATA[7:0];
          n.tbe = 1'b0;
        end
        `OFF_INTE: n.inte = I_PWDATA[6:0];
        default: ;
      endcase
    end
    // ==========================================
    // Operating clock: source select, divide, gate by enable and debug
    run = s.module_enable & (~I_DEBUG_MODE | s.clk_r[`CLK_DEBUG_CLOCK_RUN]);
    dsel = (s.clk_r[`CLK_SRC] == `SRC_INTERNAL || s.clk_r[`CLK_SRC] == `SRC_HIGH_SPEED) ?
        s.clk_r[`CLK_DIV] : 2'h0;
    if (run && I_SRC_TICK[s.clk_r[`CLK_SRC]]) begin
      if (s.div_cnt >= div_last(dsel)) begin
        n.div_cnt = 3'h0;
        n.op_tick = 1'b1;
      end else begin
        n.div_cnt = s.div_cnt + 3'h1;
      end
    end
    // ==========================================
    // Transmitter
    if (tx_tk && s.txs != uart_regs_pkg::TX_IDLE) begin
      if (s.tx_smp == last) begin
        n.tx_smp = 4'h0;
        case (s.txs)
          uart_regs_pkg::TX_START: begin
            n.txs = uart_regs_pkg::TX_DATA;
            n.tx_line = s.tx_sh[0];
          end
          uart_regs_pkg::TX_DATA: begin
            if (s.tx_bit == len_last) begin
              n.tx_bit = 3'h0;
              if (s.mod_r[`MOD_PARITY_ENABLE]) begin
                n.txs = uart_regs_pkg::TX_PAR;
                n.tx_line = s.tx_par;
              end else begin
                n.txs = uart_regs_pkg::TX_STOP;
                n.tx_line = 1'b1;
              end
            end else begin
              n.tx_bit = s.tx_bit + 3'h1;
              n.tx_sh = s.tx_sh >> 1;
              n.tx_line = s.tx_sh[1];
            end
          end
          uart_regs_pkg::TX_PAR: begin
            n.txs = uart_regs_pkg::TX_STOP;
            n.tx_line = 1'b1;
          end
          uart_regs_pkg::TX_STOP: begin
            if (s.mod_r[`MOD_STOP_LENGTH_SEL] && s.tx_bit == 3'h0) begin
              n.tx_bit = 3'h1;
            end else begin
              n.txs = uart_regs_pkg::TX_IDLE;
              tx_end = 1'b1;
            end
          end
          default: n.txs = uart_regs_pkg::TX_IDLE;
        endcase
      end else begin
        n.tx_smp = s.tx_smp + 4'h1;
      end
    end
    // Reload straight from the stop bit so busy does not dip between frames
    if ((!transmit_busy || tx_end) && !s.tbe && s.module_enable) begin
      n.tx_sh = s.txbuf;
      n.tx_par = par_of(s.txbuf, s.mod_r[`MOD_DATA_LENGTH_SEL], s.mod_r[`MOD_PARITY_TYPE]);
      n.tbe = 1'b1;
      n.txs = uart_regs_pkg::TX_START;
      n.tx_smp = 4'h0;
      n.tx_bit = 3'h0;
      n.tx_line = 1'b0;
    end
    n.tend = (s.tend & ~clr[`FLG_TEND]) | (tx_end & s.tbe);
    // ==========================================
    // Receiver front end: invert, then stretch short infrared lows
    rin = I_SIN ^ s.mod_r[`MOD_RECEIVE_INVERT];
    if (s.mod_r[`MOD_INFRARED_MODE]) begin
      if (!rin && s.ir_cnt == 4'h0) begin
        n.ir_cnt = `IR_STRETCH;
      end else if (rx_tk && s.ir_cnt != 4'h0) begin
        n.ir_cnt = s.ir_cnt - 4'h1;
      end
    end else begin
      n.ir_cnt = 4'h0;
    end
    rx_line = s.mod_r[`MOD_INFRARED_MODE] ? (rin & (s.ir_cnt == 4'h0)) : rin;
    rx_byte = s.mod_r[`MOD_DATA_LENGTH_SEL] ? s.rx_sh : {1'b0, s.rx_sh[7:1]};
    case (s.rxs)
      uart_regs_pkg::RX_IDLE: begin
        if (s.module_enable && !rx_line) begin
          n.rxs = uart_regs_pkg::RX_START;
          n.rx_smp = 4'h0;
        end
      end
      default: begin
        if (rx_tk) begin
          if ((s.rxs == uart_regs_pkg::RX_START && s.rx_smp == (last >> 1)) ||
              (s.rxs != uart_regs_pkg::RX_START && s.rx_smp == last)) begin
            n.rx_smp = 4'h0;
            case (s.rxs)
              uart_regs_pkg::RX_START: begin
                // A start bit gone high at mid-bit was noise
                if (rx_line) begin
                  n.rxs = uart_regs_pkg::RX_IDLE;
                end else begin
                  n.rxs = uart_regs_pkg::RX_DATA;
                  n.rx_bit = 3'h0;
                  n.rx_par = 1'b0;
                end
              end
              uart_regs_pkg::RX_DATA: begin
                n.rx_sh = {rx_line, s.rx_sh[7:1]};
                n.rx_par = s.rx_par ^ rx_line;
                if (s.rx_bit == len_last) begin
                  n.rxs = s.mod_r[`MOD_PARITY_ENABLE] ? uart_regs_pkg::RX_PAR : uart_regs_pkg::RX_STOP;
                end else begin
                  n.rx_bit = s.rx_bit + 3'h1;
                end
              end
              uart_regs_pkg::RX_PAR: begin
                n.rx_par = s.rx_par ^ rx_line;
                n.rxs = uart_regs_pkg::RX_STOP;
              end
              uart_regs_pkg::RX_STOP: begin
                push = 1'b1;
                fe_in = ~rx_line;
                pe_in = s.mod_r[`MOD_PARITY_ENABLE] & (s.rx_par ^ s.mod_r[`MOD_PARITY_TYPE]);
                n.rxs = uart_regs_pkg::RX_IDLE;
              end
              default: n.rxs = uart_regs_pkg::RX_IDLE;
            endcase
          end else begin
            n.rx_smp = s.rx_smp + 4'h1;
          end
        end
      end
    endcase
    // ==========================================
    // Receive FIFO; error flags rise when the bad byte reaches the head
    if (pop) begin
      n.fifo0 = s.fifo1;
      n.fe_q = {1'b0, s.fe_q[1]};
      n.pe_q = {1'b0, s.pe_q[1]};
      n.cnt = s.cnt - 2'h1;
      fe_set = (s.cnt == 2'h2) & s.fe_q[1];
      pe_set = (s.cnt == 2'h2) & s.pe_q[1];
    end
    if (push) begin
      if (n.cnt == 2'h2) begin
        ovr_set = 1'b1;
      end else if (n.cnt == 2'h0) begin
        n.fifo0 = rx_byte;
        n.fe_q[0] = fe_in;
        n.pe_q[0] = pe_in;
        fe_set = fe_set | fe_in;
        pe_set = pe_set | pe_in;
        n.cnt = 2'h1;
      end else begin
        n.fifo1 = rx_byte;
        n.fe_q[1] = fe_in;
        n.pe_q[1] = pe_in;
        n.cnt = 2'h2;
      end
    end
    n.fe = (s.fe & ~clr[`FLG_FE] & ~(pop & s.fe_q[0])) | fe_set;
    n.pe = (s.pe & ~clr[`FLG_PE] & ~(pop & s.pe_q[0])) | pe_set;
    n.ovr = (s.ovr & ~clr[`FLG_OVR]) | ovr_set;
    // ==========================================
    // Disable and soft reset; configuration and enables survive soft reset
    if (!s.module_enable) begin
      n.txs = uart_regs_pkg::TX_IDLE;
      n.rxs = uart_regs_pkg::RX_IDLE;
      n.tx_line = 1'b1;
      n.div_cnt = 3'h0;
    end
    if (s.srst) begin
      n.srst = 1'b0;
      n.txs = uart_regs_pkg::TX_IDLE;
      n.rxs = uart_regs_pkg::RX_IDLE;
      n.tx_line = 1'b1;
      n.ir_cnt = 4'h0;
      n.cnt = 2'h0;
      n.fe_q = 2'h0;
      n.pe_q = 2'h0;
      n.tbe = `TBE_RST;
      n.tend = 1'b0;
      n.fe = 1'b0;
      n.pe = 1'b0;
      n.ovr = 1'b0;
    end
    n.irq = |(flags & s.inte);
    // ==========================================
    // Line driver: infrared low lasts the first 3 samples of a bit (of 16, or of 4), then invert, then drive mode
    line_out = s.mod_r[`MOD_INFRARED_MODE] ? ~(~s.tx_line & (s.tx_smp < `IR_LOW_SMP)) : s.tx_line;
    n.sout = line_out ^ s.mod_r[`MOD_TRANSMIT_INVERT];
    n.sout_oe = s.mod_r[`MOD_OUTPUT_DRIVE_MODE] ? ~n.sout : 1'b1;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      s <= '0;
      s.tbe <= `TBE_RST;
      s.tx_line <= 1'b1;
      s.sout <= 1'b1;
      s.sout_oe <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign O_PREADY = s.pready;
  assign O_PRDATA = s.prdata;
  assign O_PSLVERR = s.pslverr;
  assign O_SOUT = s.sout;
  assign O_SOUT_OE = s.sout_oe;
  assign O_SIN_PULLUP = s.mod_r[`MOD_INPUT_PULLUP_ENABLE];
  assign O_IRQ = s.irq;

  // ==========================================
  // Checks
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  a_apb_ready: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (I_PSEL && !I_PENABLE && I_PADDR > `OFF_INTE
    |=> O_PSLVERR && O_PRDATA == 32'h00000000)
    else $error("unmapped address not refused");
  a_tbe_clear: assert property (wr && I_PADDR == `OFF_TXD && s.tbe |=> !s.tbe)
    else $error("empty flag kept after data write");
  a_tx_start: assert property (wr && I_PADDR == `OFF_TXD && s.tbe && !transmit_busy && s.module_enable
    && !s.srst |-> ##2 s.txs == uart_regs_pkg::TX_START)
    else $error("written byte not started");
  a_module_enable_gate: assert property (!s.module_enable |=> !s.op_tick)
    else $error("op clock while disabled");
  a_dbg_hold: assert property (I_DEBUG_MODE && !s.clk_r[`CLK_DEBUG_CLOCK_RUN] |=> !s.op_tick)
    else $error("op clock in debug mode");
  a_srst_flags: assert property (s.srst |=> s.tbe && !s.tend && !s.ovr && s.cnt == 2'h0
    && !s.srst && !transmit_busy)
    else $error("soft reset incomplete");
  a_fifo_order: assert property (pop && !push && s.cnt == 2'h2 && !s.srst
    |=> s.fifo0 == $past(s.fifo1) && s.cnt == 2'h1)
    else $error("fifo order broken");
  a_ovr_set: assert property (push && s.cnt == 2'h2 && !pop && !s.srst |=> s.ovr)
    else $error("overrun not flagged");
  a_irq_gate: assert property (O_IRQ |-> $past(|(flags & s.inte)))
    else $error("irq without enabled flag");
  a_od_drive: assert property ($past(s.mod_r[`MOD_OUTPUT_DRIVE_MODE]) |-> O_SOUT_OE == !O_SOUT)
    else $error("open-drain drives high");
  a_fe_read: assert property (pop && s.fe_q[0] && !fe_set && !s.srst |=> !s.fe)
    else $error("framing flag kept after read");

  c_tx_end: cover property (tx_end && s.tbe);
  c_overrun: cover property (ovr_set);
  c_two_full: cover property (s.cnt == 2'h2 ##[1:50] pop);
  c_frame_err: cover property (fe_set);
endmodule

// ---- tb/uart_line_echo.sv ----
`timescale 1ns/10ps
// ==========================================
// Far-side serial device: echoes the line back after LAT cycles
module uart_line_echo #(
  parameter int LAT = 5
) (
  input wire logic i_clk,
  input wire logic i_sout,
  input wire logic i_sout_oe,
  output logic o_sin
);
  logic [LAT-1:0] dly_ff = '1;
  logic line;
  // A released open-drain line floats up to the pull-up level
  assign line = i_sout_oe ? i_sout : 1'b1;
  // A pure delay keeps back-to-back frames intact, unlike a store-and-forward echo
  always @(posedge i_clk) begin
    dly_ff <= {dly_ff[LAT-2:0], line};
  end
  assign o_sin = dly_ff[LAT-1];
endmodule

// ---- tb/uart_control_register_set_test.sv ----
`timescale 1ns/10ps
// ==========================================
// Register and loopback bench
module uart_control_register_set_test;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, dbg = 0, sin;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r, d, prdata;
  logic pready, pslverr, sout, soe, pull, irq;
  logic [33:0] notes[$];
  logic [33:0] nt;
  logic [7:0] b0, b1;
  logic [7:0] offs[4] = '{8'h00, 8'h04, 8'h08, 8'h1c};
  logic [31:0] msk[4] = '{32'h133, 32'h77f, 32'hfff, 32'h7f};
  int n_errors = 0, total_checks = 0, cycles = 0, seed = 32'hbb99;
  always #4 clk = ~clk;
  uart_regs_top u_uart_regs_top (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_SRC_TICK(4'hf),
    .I_DEBUG_MODE(dbg), .I_SIN(sin), .O_SOUT(sout), .O_SOUT_OE(soe),
    .O_SIN_PULLUP(pull), .O_IRQ(irq));
  uart_line_echo u_uart_line_echo (.i_clk(clk), .i_sout(sout), .i_sout_oe(soe), .o_sin(sin));
  // ==========================================
  // Checking
  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sampled on the falling edge so the compare never races the design's update
  always @(negedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      nt = notes.pop_front();
      if (nt[33]) check("apb read", {pslverr, prdata}, nt[32:0]);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  // ==========================================
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic c, input logic [32:0] e);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    notes.push_back({c, e});
    @(posedge clk);
    pen <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1) @(negedge clk);
    @(posedge clk);
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b1, {1'b0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 1'b0, 33'h0);
  endtask
  task automatic wait_flag(input int b);
    repeat (200) begin
      apb(1'b0, 8'h18, 32'h0, 1'b0, 33'h0);
      if (r[b] === 1'b1) break;
    end
    check("status flag", {32'h0, r[b]}, 33'h1);
  endtask
  task automatic irq_is(input logic v);
    @(negedge clk);
    check("irq", {32'h0, irq}, {32'h0, v});
    @(posedge clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("line idle", {30'h0, pull, soe, sout}, 33'h3);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), (i == 6) ? 32'h1 : 32'h0);
    apb(1'b0, 8'h20, 32'h0, 1'b1, {1'b1, 32'h0});
    foreach (offs[i]) begin
      d = $random(seed);
      wr(offs[i], d);
      rd(offs[i], d & msk[i]);
      // Idle line after invert, open-drain enable and pull-up follow the mode word
      if (i == 1) check("line mode", {30'h0, pull, soe, sout},
          {30'h0, d[6], ~d[5] | d[8], ~d[8]});
    end
    // Fastest legal rate keeps frames to 80 cycles
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h408);
    wr(8'h08, 32'h1);
    wr(8'h1c, 32'h4);
    wr(8'h0c, 32'h1);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    wr(8'h10, {24'h0, b0});
    wait_flag(0);
    wr(8'h10, {24'h0, b1});
    wait_flag(2);
    repeat (20) @(posedge clk);
    irq_is(1'b1);
    rd(8'h18, 32'h47);
    rd(8'h14, {24'h0, b0});
    irq_is(1'b0);
    rd(8'h14, {24'h0, b1});
    rd(8'h18, 32'h41);
    wr(8'h18, 32'h40);
    rd(8'h18, 32'h1);
    // Debug without clock-run freezes both sides; the echoed frame is garbled, so only count it
    dbg <= 1'b1;
    wr(8'h10, {24'h0, b0});
    repeat (200) @(posedge clk);
    rd(8'h18, 32'h301);
    dbg <= 1'b0;
    wait_flag(6);
    wait_flag(1);
    wr(8'h0c, 32'h3);
    rd(8'h0c, 32'h1);
    rd(8'h18, 32'h1);
    stop_test;
  end
endmodule
